/* File: inc/cpu_tail_defs.svh */
`ifndef CPU_TAIL_DEFS_SVH
`define CPU_TAIL_DEFS_SVH

`define OP_SUB_IX1 16'h00E0
`define OP_SUB_IX 16'h00F0
`define OP_SUB_IX2 16'h00D0
`define OP_SUB_SP2 16'h9ED0
`define OP_SUB_SP1 16'h9EE0
`define OP_TST_DIR 16'h003D
`define OP_TST_A 16'h004D
`define OP_TST_X 16'h005D
`define OP_TST_IX1 16'h006D
`define OP_TST_IX 16'h007D
`define OP_TST_SP1 16'h9E6D
`define OP_SWI 16'h0083
`define OP_TAP 16'h0084
`define OP_TPA 16'h0085
`define OP_TAX 16'h0097
`define OP_TXA 16'h009F
`define OP_TSX 16'h0095
`define OP_TXS 16'h0094
`define OP_WAIT 16'h008F

// Cycle counts, stored as the last cycle index (count minus one)
`define CYC_SUB_IX 4'h2
`define CYC_SUB_IX1 4'h2
`define CYC_SUB_IX2 4'h3
`define CYC_SUB_SP1 4'h3
`define CYC_SUB_SP2 4'h4
`define CYC_TST_INH 4'h0
`define CYC_TST_DIR 4'h3
`define CYC_TST_IX 4'h2
`define CYC_TST_IX1 4'h3
`define CYC_TST_SP1 4'h4
`define CYC_SWI 4'hA
`define CYC_XFER 4'h0
`define CYC_SPX 4'h1
`define CYC_WAIT_MIN 4'h2

// Bus activity points inside an instruction
`define CNT_RD_ISSUE 4'h0
`define CNT_RD_DATA 4'h2
`define CNT_PUSH_LAST 4'h4
`define CNT_VEC_HI_ISSUE 4'h5
`define CNT_VEC_LO_ISSUE 4'h6
`define CNT_VEC_HI_DATA 4'h7
`define CNT_VEC_LO_DATA 4'h8

`define VEC_HI_ADDR 16'hFFFC
`define VEC_LO_ADDR 16'hFFFD

// Flag bit positions
`define CCR_V 7
`define CCR_H 4
`define CCR_I 3
`define CCR_N 2
`define CCR_Z 1
`define CCR_C 0

// Register port map
`define REG_ACC 4'h0
`define REG_IDX_LO 4'h1
`define REG_IDX_HI 4'h2
`define REG_SP_LO 4'h3
`define REG_SP_HI 4'h4
`define REG_PC_LO 4'h5
`define REG_PC_HI 4'h6
`define REG_FLAGS 4'h7
`define REG_STATUS 4'h8

`define RST_ACC 8'h00
`define RST_IDX 16'h0000
`define RST_SP 16'h00FF
`define RST_PC 16'h0000
`define RST_FLAGS 8'h68

`endif

/* File: inc/cpu_tail_pkg.sv */
package cpu_tail_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b100
  } run_state_t;

  typedef enum logic [3:0] {
    CL_BAD, CL_SUB, CL_TST, CL_SWI, CL_TAP, CL_TPA, CL_TAX, CL_TXA, CL_TSX, CL_TXS, CL_WAIT
  } op_class_t;

  typedef enum logic [2:0] {
    AM_INH, AM_DIR, AM_IX, AM_IX1, AM_IX2, AM_SP1, AM_SP2
  } addr_mode_t;

  typedef struct packed {
    op_class_t cls;
    addr_mode_t mode;
    logic [3:0] last;
  } op_info_t;

endpackage

/* File: inc/alu_if.sv */
`timescale 1ns/1ps
interface alu_if;
  logic [7:0] a;
  logic [7:0] m;
  logic sel_test;
  logic [7:0] res;
  logic flag_v;
  logic flag_n;
  logic flag_z;
  logic flag_c;

  modport alu (
    input a,
    input m,
    input sel_test,
    output res,
    output flag_v,
    output flag_n,
    output flag_z,
    output flag_c
  );

  modport user (
    output a,
    output m,
    output sel_test,
    input res,
    input flag_v,
    input flag_n,
    input flag_z,
    input flag_c
  );
endinterface

/* File: logic/sub_flag_alu.sv */
`timescale 1ns/1ps
module sub_flag_alu (
  alu_if.alu bus
);
  wire [7:0] diff;
  wire [7:0] res_w;

  assign diff = bus.a - bus.m;
  // Probe passes the operand through so N and Z come from it
  assign res_w = bus.sel_test ? bus.a : diff;
  assign bus.res = res_w;
  assign bus.flag_n = res_w[7];
  assign bus.flag_z = (res_w == 8'h00);
  assign bus.flag_v = bus.sel_test ? 1'b0 :
    ((bus.a[7] & ~bus.m[7] & ~diff[7]) | (~bus.a[7] & bus.m[7] & diff[7]));
  assign bus.flag_c = (~bus.a[7] & bus.m[7]) | (bus.m[7] & diff[7]) | (diff[7] & ~bus.a[7]);
endmodule

/* File: logic/cpu_tail_opcode_executor.sv */
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "cpu_tail_defs.svh"
module cpu_tail_opcode_executor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic exec_start,
  input wire logic [15:0] exec_opcode,
  input wire logic [15:0] exec_operand,
  output logic exec_busy,
  output logic exec_done,
  output logic exec_illegal,
  output logic halted,
  output cpu_tail_pkg::run_state_t run_state,
  input wire logic irq_pending,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import cpu_tail_pkg::*;

  function automatic op_info_t decode(input logic [15:0] opc);
    op_info_t d;
    d = '{cls: CL_BAD, mode: AM_INH, last: 4'h0};
    case (opc)
      `OP_SUB_IX1: d = '{cls: CL_SUB, mode: AM_IX1, last: `CYC_SUB_IX1};
      `OP_SUB_IX: d = '{cls: CL_SUB, mode: AM_IX, last: `CYC_SUB_IX};
      `OP_SUB_IX2: d = '{cls: CL_SUB, mode: AM_IX2, last: `CYC_SUB_IX2};
      `OP_SUB_SP2: d = '{cls: CL_SUB, mode: AM_SP2, last: `CYC_SUB_SP2};
      `OP_SUB_SP1: d = '{cls: CL_SUB, mode: AM_SP1, last: `CYC_SUB_SP1};
      `OP_TST_DIR: d = '{cls: CL_TST, mode: AM_DIR, last: `CYC_TST_DIR};
      `OP_TST_A: d = '{cls: CL_TST, mode: AM_INH, last: `CYC_TST_INH};
      `OP_TST_X: d = '{cls: CL_TST, mode: AM_INH, last: `CYC_TST_INH};
      `OP_TST_IX1: d = '{cls: CL_TST, mode: AM_IX1, last: `CYC_TST_IX1};
      `OP_TST_IX: d = '{cls: CL_TST, mode: AM_IX, last: `CYC_TST_IX};
      `OP_TST_SP1: d = '{cls: CL_TST, mode: AM_SP1, last: `CYC_TST_SP1};
      `OP_SWI: d = '{cls: CL_SWI, mode: AM_INH, last: `CYC_SWI};
      `OP_TAP: d = '{cls: CL_TAP, mode: AM_INH, last: `CYC_XFER};
      `OP_TPA: d = '{cls: CL_TPA, mode: AM_INH, last: `CYC_XFER};
      `OP_TAX: d = '{cls: CL_TAX, mode: AM_INH, last: `CYC_XFER};
      `OP_TXA: d = '{cls: CL_TXA, mode: AM_INH, last: `CYC_XFER};
      `OP_TSX: d = '{cls: CL_TSX, mode: AM_INH, last: `CYC_SPX};
      `OP_TXS: d = '{cls: CL_TXS, mode: AM_INH, last: `CYC_SPX};
      `OP_WAIT: d = '{cls: CL_WAIT, mode: AM_INH, last: `CYC_WAIT_MIN};
      default: d = '{cls: CL_BAD, mode: AM_INH, last: 4'h0};
    endcase
    return d;
  endfunction

  run_state_t state_r;
  run_state_t state_nxt;
  op_class_t cls_r;
  addr_mode_t mode_r;
  logic [3:0] last_r;
  logic [3:0] cnt_r;
  logic [15:0] opc_r;
  logic [15:0] opnd_r;
  logic [7:0] acc_r;
  logic [7:0] idx_lo_r;
  logic [7:0] idx_hi_r;
  logic [15:0] sp_r;
  logic [15:0] pc_r;
  logic [7:0] flags_r;
  logic [7:0] m_r;
  logic [7:0] vec_hi_r;
  logic illegal_r;
  logic [15:0] mem_addr_nxt;
  logic [7:0] mem_wdata_nxt;
  logic mem_wr_nxt;
  logic mem_rd_nxt;
  logic [7:0] reg_rdata_nxt;

  op_info_t info_w;
  wire start_ok;
  wire running;
  wire last_cycle;
  wire finish;
  wire needs_mem;
  wire [15:0] idx_pair;
  wire [15:0] ea;
  wire [15:0] pc_inc;
  wire [7:0] operand;
  wire [7:0] probe_src;
  wire [7:0] push_data;
  wire reg_wr_ok;
  alu_if alu_bus ();

  assign info_w = decode(exec_opcode);
  assign start_ok = exec_start && (state_r == ST_IDLE);
  assign running = (state_r == ST_RUN);
  assign last_cycle = running && (cnt_r == last_r);
  // Wait stays in the halt state until the interrupt logic raises its request
  assign finish = (last_cycle && (cls_r != CL_WAIT)) || (state_r == ST_HALT && irq_pending) ||
    (last_cycle && cls_r == CL_WAIT && irq_pending);
  assign needs_mem = (mode_r != AM_INH);
  assign idx_pair = {idx_hi_r, idx_lo_r};
  assign pc_inc = pc_r + 16'h0001;

  assign ea = (mode_r == AM_DIR) ? {8'h00, opnd_r[7:0]} :
              (mode_r == AM_IX) ? idx_pair :
              (mode_r == AM_IX1) ? idx_pair + {8'h00, opnd_r[7:0]} :
              (mode_r == AM_IX2) ? idx_pair + opnd_r :
              (mode_r == AM_SP1) ? sp_r + {8'h00, opnd_r[7:0]} :
              sp_r + opnd_r;

  // Read data is valid only in the cycle after the strobe, so pick it live there
  assign operand = (cnt_r == `CNT_RD_DATA) ? mem_rdata : m_r;
  assign probe_src = (mode_r != AM_INH) ? operand :
                     (opc_r == `OP_TST_X) ? idx_lo_r : acc_r;

  // Stacking order: return address low, high, index low, accumulator, flags
  assign push_data = (cnt_r == 4'h0) ? pc_inc[7:0] :
                     (cnt_r == 4'h1) ? pc_inc[15:8] :
                     (cnt_r == 4'h2) ? idx_lo_r :
                     (cnt_r == 4'h3) ? acc_r : flags_r;

  assign alu_bus.a = (cls_r == CL_TST) ? probe_src : acc_r;
  assign alu_bus.m = operand;
  assign alu_bus.sel_test = (cls_r == CL_TST);

  sub_flag_alu u_alu (
    .bus(alu_bus)
  );

  // Software may not disturb the register set mid-instruction
  assign reg_wr_ok = reg_wr && (state_r == ST_IDLE) && !exec_start;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_ok && info_w.cls != CL_BAD) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (finish) begin
          state_nxt = ST_IDLE;
        end else if (last_cycle) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (irq_pending) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    mem_addr_nxt = 16'h0000;
    mem_wdata_nxt = 8'h00;
    mem_wr_nxt = 1'b0;
    mem_rd_nxt = 1'b0;
    if (running && needs_mem && cnt_r == `CNT_RD_ISSUE) begin
      mem_rd_nxt = 1'b1;
      mem_addr_nxt = ea;
    end
    if (running && cls_r == CL_SWI) begin
      if (cnt_r <= `CNT_PUSH_LAST) begin
        mem_wr_nxt = 1'b1;
        mem_addr_nxt = sp_r;
        mem_wdata_nxt = push_data;
      end else if (cnt_r == `CNT_VEC_HI_ISSUE) begin
        mem_rd_nxt = 1'b1;
        mem_addr_nxt = `VEC_HI_ADDR;
      end else if (cnt_r == `CNT_VEC_LO_ISSUE) begin
        mem_rd_nxt = 1'b1;
        mem_addr_nxt = `VEC_LO_ADDR;
      end
    end
  end

  always_comb begin
    unique case (reg_addr)
      `REG_ACC: reg_rdata_nxt = acc_r;
      `REG_IDX_LO: reg_rdata_nxt = idx_lo_r;
      `REG_IDX_HI: reg_rdata_nxt = idx_hi_r;
      `REG_SP_LO: reg_rdata_nxt = sp_r[7:0];
      `REG_SP_HI: reg_rdata_nxt = sp_r[15:8];
      `REG_PC_LO: reg_rdata_nxt = pc_r[7:0];
      `REG_PC_HI: reg_rdata_nxt = pc_r[15:8];
      `REG_FLAGS: reg_rdata_nxt = flags_r;
      `REG_STATUS: reg_rdata_nxt = {5'b00000, illegal_r, state_r == ST_HALT, state_r != ST_IDLE};
      default: reg_rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cls_r <= CL_BAD;
      mode_r <= AM_INH;
      last_r <= 4'h0;
      opc_r <= 16'h0000;
      opnd_r <= 16'h0000;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (start_ok) begin
        cls_r <= info_w.cls;
        mode_r <= info_w.mode;
        last_r <= info_w.last;
        opc_r <= exec_opcode;
        opnd_r <= exec_operand;
        cnt_r <= 4'h0;
      end else if (running && !last_cycle) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      reg_rdata <= 8'h00;
      m_r <= 8'h00;
      vec_hi_r <= 8'h00;
      illegal_r <= 1'b0;
    end else begin
      mem_addr <= mem_addr_nxt;
      mem_wdata <= mem_wdata_nxt;
      mem_wr <= mem_wr_nxt;
      mem_rd <= mem_rd_nxt;
      reg_rdata <= reg_rd ? reg_rdata_nxt : 8'h00;
      if (running && (cnt_r == `CNT_RD_DATA || (cls_r == CL_SWI && cnt_r == `CNT_VEC_LO_DATA))) begin
        m_r <= mem_rdata;
      end
      if (running && cls_r == CL_SWI && cnt_r == `CNT_VEC_HI_DATA) begin
        vec_hi_r <= mem_rdata;
      end
      if (start_ok) begin
        illegal_r <= (info_w.cls == CL_BAD);
      end
    end
  end

  // Architectural registers: results land on the last-cycle edge, except trap pushes step SP and wait clears I at its first cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= `RST_ACC;
      {idx_hi_r, idx_lo_r} <= `RST_IDX;
      sp_r <= `RST_SP;
      pc_r <= `RST_PC;
      flags_r <= `RST_FLAGS;
    end else if (reg_wr_ok) begin
      unique case (reg_addr)
        `REG_ACC: acc_r <= reg_wdata;
        `REG_IDX_LO: idx_lo_r <= reg_wdata;
        `REG_IDX_HI: idx_hi_r <= reg_wdata;
        `REG_SP_LO: sp_r[7:0] <= reg_wdata;
        `REG_SP_HI: sp_r[15:8] <= reg_wdata;
        `REG_PC_LO: pc_r[7:0] <= reg_wdata;
        `REG_PC_HI: pc_r[15:8] <= reg_wdata;
        `REG_FLAGS: flags_r <= reg_wdata;
        default: ;
      endcase
    end else begin
      if (running && cls_r == CL_SWI && cnt_r <= `CNT_PUSH_LAST) begin
        sp_r <= sp_r - 16'h0001;
      end
      if (running && cls_r == CL_WAIT && cnt_r == 4'h0) begin
        flags_r[`CCR_I] <= 1'b0;
      end
      if (last_cycle) begin
        unique case (cls_r)
          CL_SUB: begin
            acc_r <= alu_bus.res;
            flags_r[`CCR_V] <= alu_bus.flag_v;
            flags_r[`CCR_N] <= alu_bus.flag_n;
            flags_r[`CCR_Z] <= alu_bus.flag_z;
            flags_r[`CCR_C] <= alu_bus.flag_c;
          end
          CL_TST: begin
            flags_r[`CCR_V] <= 1'b0;
            flags_r[`CCR_N] <= alu_bus.flag_n;
            flags_r[`CCR_Z] <= alu_bus.flag_z;
          end
          CL_SWI: begin
            flags_r[`CCR_I] <= 1'b1;
            pc_r <= {vec_hi_r, m_r};
          end
          CL_TAP: flags_r <= acc_r;
          CL_TPA: acc_r <= flags_r;
          CL_TAX: idx_lo_r <= acc_r;
          CL_TXA: acc_r <= idx_lo_r;
          CL_TSX: {idx_hi_r, idx_lo_r} <= sp_r + 16'h0001;
          CL_TXS: sp_r <= idx_pair - 16'h0001;
          default: ;
        endcase
      end
    end
  end

  // Low vector byte reuses the operand capture, taken at the vector low data cycle (CNT_VEC_LO_DATA)
  always_comb begin
    exec_busy = (state_r != ST_IDLE);
    exec_done = finish;
    exec_illegal = illegal_r;
    halted = (state_r == ST_HALT);
    run_state = state_r;
  end
endmodule

/* File: verif/mem_partner.sv */
`timescale 1ns/1ps
module mem_partner (
  input wire logic clk_sys,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
  end
  // Off the data cycle the bus inverts every clock, so a sample one cycle late finds the byte inverted
  always @(posedge clk_sys) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
  end
endmodule

/* File: verif/cpu_tail_asserts.sv */
`timescale 1ns/1ps
module cpu_tail_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic exec_start,
  input wire logic [15:0] exec_opcode,
  input wire logic exec_busy,
  input wire logic exec_done,
  input wire logic halted,
  input wire logic irq_pending,
  input wire logic mem_wr,
  input wire logic mem_rd
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic go;
  assign go = exec_start && !exec_busy;
  sub_read_a: assert property (go && exec_opcode == 16'h00F0 |=> !mem_rd ##1 mem_rd ##1 exec_done)
    else $error("subtract read or finish misplaced");
  idle_bus_a: assert property (!exec_busy |-> !mem_wr && !mem_rd)
    else $error("memory strobe while idle");
  trap_pushes_a: assert property (go && exec_opcode == 16'h0083 |=> !mem_wr ##1 mem_wr [*5] ##1 mem_rd)
    else $error("trap stacking sequence wrong");
  trap_length_a: assert property (go && exec_opcode == 16'h0083 |=>
    !exec_done [*5] ##1 !exec_done [*5] ##1 exec_done)
    else $error("trap length not eleven");
  xfer_single_a: assert property (go && exec_opcode inside {16'h0084, 16'h0085, 16'h0097, 16'h009F,
    16'h004D, 16'h005D} |=> exec_done)
    else $error("transfer not single cycle");
  pair_two_a: assert property (go && exec_opcode inside {16'h0094, 16'h0095} |=> !exec_done ##1 exec_done)
    else $error("pair transfer not two cycles");
  probe_direct_a: assert property (go && exec_opcode == 16'h003D |=> !exec_done [*3] ##1 exec_done)
    else $error("direct probe not four cycles");
  wait_min_a: assert property (go && exec_opcode == 16'h008F |=> !exec_done [*2])
    else $error("wait finished too early");
  wake_done_a: assert property (halted && irq_pending |-> exec_done)
    else $error("halt not ended by interrupt");
  done_pulse_a: assert property (exec_done |=> !exec_done)
    else $error("done longer than one cycle");
endmodule

bind cpu_tail_opcode_executor cpu_tail_asserts chk_i (.clk_sys, .rst_n, .exec_start, .exec_opcode, .exec_busy,
  .exec_done, .halted, .irq_pending, .mem_wr, .mem_rd);

/* File: verif/cpu_tail_opcode_executor_tb_top.sv */
`timescale 1ns/1ps
`include "cpu_tail_defs.svh"
module cpu_tail_opcode_executor_tb_top;
  import cpu_tail_pkg::*;
  logic clk_sys = 0, rst_n = 0, exec_start = 0, irq_pending = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] exec_opcode = 0, exec_operand = 0, mem_addr;
  logic [7:0] mem_wdata, mem_rdata, reg_wdata = 0, reg_rdata;
  logic [3:0] reg_addr = 0;
  logic exec_busy, exec_done, exec_illegal, halted, mem_wr, mem_rd;
  run_state_t run_state;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  logic [7:0] a, x, h, f, m, v;
  logic [15:0] s, p, ea;
  logic [15:0] so[5] = '{16'h00E0, 16'h00F0, 16'h00D0, 16'h9ED0, 16'h9EE0};
  int sm[5] = '{1, 0, 2, 4, 3};
  int sn[5] = '{3, 3, 4, 5, 4};
  logic [15:0] to[6] = '{16'h003D, 16'h004D, 16'h005D, 16'h006D, 16'h007D, 16'h9E6D};
  int tm[6] = '{5, 6, 6, 1, 0, 3};
  int tn[6] = '{4, 1, 1, 4, 3, 5};
  logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h68, 8'h00};

  cpu_tail_opcode_executor dut (.clk_sys, .rst_n, .exec_start, .exec_opcode, .exec_operand, .exec_busy,
    .exec_done, .exec_illegal, .halted, .run_state, .irq_pending, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
    .mem_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  mem_partner mem (.clk_sys, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata);

  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      test_done();
    end
  end

  task test_done;
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(logic [3:0] ad, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(logic [3:0] ad, logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %0h", ad), e, reg_rdata);
  endtask

  task rnd;
    a = 8'($urandom);
    x = 8'($urandom);
    h = 8'($urandom);
    m = 8'($urandom);
    f = 8'($urandom) | 8'h60;
    p = 16'($urandom);
    s = 16'($urandom) & 16'h7FFF | 16'h0010;
  endtask

  task load;
    wr(`REG_ACC, a);
    wr(`REG_IDX_LO, x);
    wr(`REG_IDX_HI, h);
    wr(`REG_FLAGS, f);
    wr(`REG_SP_LO, s[7:0]);
    wr(`REG_SP_HI, s[15:8]);
  endtask

  function automatic logic [15:0] eaf(int md);
    case (md)
      0: return {h, x};
      1: return {h, x} + p[7:0];
      2: return {h, x} + p;
      3: return s + p[7:0];
      4: return s + p;
      default: return {8'h00, p[7:0]};
    endcase
  endfunction

  function automatic logic [7:0] subf(logic [7:0] a0, logic [7:0] m0, logic [7:0] f0);
    logic [7:0] d;
    d = a0 - m0;
    return {(a0[7] & ~m0[7] & ~d[7]) | (~a0[7] & m0[7] & d[7]), f0[6:3], d[7], d == 8'h00, m0 > a0};
  endfunction

  // Done is sampled mid-cycle, so a combinational pulse in the wake cycle is not missed
  task automatic run(logic [15:0] op, logic [15:0] opr, int n, bit w);
    int k;
    @(posedge clk_sys);
    exec_start <= 1'b1;
    exec_opcode <= op;
    exec_operand <= opr;
    @(posedge clk_sys);
    exec_start <= 1'b0;
    for (k = 0; k < 60; k++) begin
      @(negedge clk_sys);
      if (w && k == 4) begin
        chk("halted", 1, halted);
        chk("state", 16'h0004, run_state);
        @(posedge clk_sys);
        irq_pending <= 1'b1;
      end
      if (exec_done === 1'b1) break;
    end
    chk("done", 1, exec_done);
    if (n > 0) chk("cycles", n, k + 1);
    @(posedge clk_sys);
    irq_pending <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'hafaf));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(4'(i), rv[i]);
    rd(4'hF, 8'h00);
    for (int i = 0; i < 10; i++) begin
      rnd();
      if (i == 0) {a, m} = 16'h8001;
      if (i == 1) m = a;
      load();
      mem.mem[eaf(sm[i % 5])] = m;
      run(so[i % 5], p, sn[i % 5], 0);
      rd(`REG_ACC, a - m);
      rd(`REG_FLAGS, subf(a, m, f));
    end
    for (int i = 0; i < 12; i++) begin
      rnd();
      if (i > 5) {a, x, m} = 24'h00_0000;
      load();
      mem.mem[eaf(tm[i % 6])] = m;
      v = i % 6 == 1 ? a : i % 6 == 2 ? x : m;
      run(to[i % 6], p, tn[i % 6], 0);
      rd(`REG_FLAGS, {1'b0, f[6:3], v[7], v == 8'h00, f[0]});
      rd(`REG_ACC, a);
    end
    rnd();
    load();
    run(16'h0084, 0, 1, 0);
    rd(`REG_FLAGS, a);
    load();
    run(16'h0085, 0, 1, 0);
    rd(`REG_ACC, f);
    rd(`REG_FLAGS, f);
    rnd();
    load();
    run(16'h0097, 0, 1, 0);
    rd(`REG_IDX_LO, a);
    rd(`REG_IDX_HI, h);
    rd(`REG_FLAGS, f);
    rnd();
    load();
    run(16'h009F, 0, 1, 0);
    rd(`REG_ACC, x);
    rd(`REG_FLAGS, f);
    rnd();
    load();
    ea = s + 16'h0001;
    run(16'h0095, 0, 2, 0);
    rd(`REG_IDX_LO, ea[7:0]);
    rd(`REG_IDX_HI, ea[15:8]);
    rnd();
    load();
    ea = {h, x} - 16'h0001;
    run(16'h0094, 0, 2, 0);
    rd(`REG_SP_LO, ea[7:0]);
    rd(`REG_SP_HI, ea[15:8]);
    rd(`REG_FLAGS, f);
    rnd();
    load();
    wr(`REG_PC_LO, p[7:0]);
    wr(`REG_PC_HI, p[15:8]);
    v = 8'($urandom);
    mem.mem[`VEC_HI_ADDR] = m;
    mem.mem[`VEC_LO_ADDR] = v;
    ea = p + 16'h0001;
    run(16'h0083, 0, 11, 0);
    for (int i = 0; i < 5; i++) chk("push", i == 0 ? ea[7:0] : i == 1 ? ea[15:8] : i == 2 ? x : i == 3 ? a : f,
      mem.mem[s - 16'(i)]);
    ea = s - 16'h0005;
    rd(`REG_SP_LO, ea[7:0]);
    rd(`REG_SP_HI, ea[15:8]);
    rd(`REG_PC_HI, m);
    rd(`REG_PC_LO, v);
    rd(`REG_FLAGS, f | 8'h08);
    f = f | 8'h08;
    load();
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    run(16'h008F, 0, 3, 0);
    rd(`REG_FLAGS, f & 8'hF7);
    load();
    run(16'h008F, 0, 0, 1);
    rd(`REG_FLAGS, f & 8'hF7);
    @(posedge clk_sys);
    exec_start <= 1'b1;
    exec_opcode <= 16'h0001;
    @(posedge clk_sys);
    exec_start <= 1'b0;
    #1 chk("illegal", 1, exec_illegal);
    chk("busy", 0, exec_busy);
    test_done();
  end
endmodule
